// >>> common/tcp_pkg.sv
// Shared constants of the timer/counter with its prescaler
package tcp_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_COUNT     = 8'h01;
    localparam logic [7:0] ADDR_INTCTL    = 8'h0B;
    localparam logic [7:0] ADDR_INTCTL_HI = 8'h8B;
    localparam logic [7:0] ADDR_OPTION    = 8'h81;
    localparam logic [7:0] ADDR_PORTA_DIR = 8'h85;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int OPT_CS     = 5;
    localparam int OPT_SE     = 4;
    localparam int OPT_PSA    = 3;
    localparam int OPT_PS_LSB = 0;
    localparam int INT_FLAG   = 2;
    localparam int INT_IE     = 5;

    // ----------------------------------------------------------------
    // Reset values and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_COUNT     = 8'h00;
    localparam logic [7:0] RST_INTCTL    = 8'h00;
    localparam logic [7:0] RST_OPTION    = 8'hFF;
    localparam logic [7:0] RST_PORTA_DIR = 8'h1F;
    localparam logic [7:0] PORTA_MASK    = 8'h1F;

    // ----------------------------------------------------------------
    // Timing: four phase clocks make one instruction cycle
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS  = 25;
    localparam logic [1:0] PH_Q2          = 2'h1;
    localparam logic [1:0] PH_Q4          = 2'h3;
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
endpackage

// >>> design/tcp_prescaler.sv
// Shared 8-bit prescaler counter with ratio selection
`timescale 1ns/1ps
module tcp_prescaler (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       src,
    input  wire logic       clear,
    input  wire logic [2:0] ratio,
    output logic            pre_out,
    output logic [7:0]      pre_count
);
    logic src_prev;
    wire  step = src & ~src_prev;

    // Counts rising edges of the source; clear beats a step
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            src_prev  <= 1'b0;
            pre_count <= 8'h00;
        end else begin
            src_prev  <= src;
            if (clear)
                pre_count <= 8'h00;
            else if (step)
                pre_count <= pre_count + 8'h01;
        end
    end

    // Bit n toggles every 2^n steps: symmetric output, ratio 2^(n+1)
    assign pre_out = pre_count[ratio];

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_pre_clear;
        clear |=> pre_count == 8'h00;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

    property p_pre_step;
        step && !clear |=> pre_count == $past(pre_count) + 8'h01;
    endproperty
    a_pre_step: assert property (p_pre_step) else $error("prescaler missed step");
endmodule

// >>> design/tcp_timer.sv
// Timer/counter top: registers, phase clocks, synchroniser, overflow flag
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module tcp_timer (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rdata,
    input  wire logic       external_count_input,
    input  wire logic       sleep_mode,
    input  wire logic       watchdog_clear_op,
    input  wire logic       watchdog_tick,
    output logic            overflow_irq,
    output logic            watchdog_timeout,
    output logic [7:0]      port_a_direction
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] count_register;
    logic [7:0] interrupt_control;
    logic [7:0] option_control;
    logic [1:0] phase;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_s3;
    logic       pin_level;
    logic       sample;
    logic       inc_pulse;
    logic [1:0] inhibit;
    logic       wdt_prev;

    // ----------------------------------------------------------------
    // Address decode and option fields
    // ----------------------------------------------------------------
    wire       hit_count  = addr == tcp_pkg::ADDR_COUNT;
    wire       hit_intctl = (addr == tcp_pkg::ADDR_INTCTL)
                          | (addr == tcp_pkg::ADDR_INTCTL_HI);
    wire       hit_option = addr == tcp_pkg::ADDR_OPTION;
    wire       hit_porta  = addr == tcp_pkg::ADDR_PORTA_DIR;
    wire       wr_count   = wr_en & hit_count;
    wire       wr_intctl  = wr_en & hit_intctl;

    wire       clock_source_select  = option_control[tcp_pkg::OPT_CS];
    wire       source_edge_select   = option_control[tcp_pkg::OPT_SE];
    wire       prescaler_assign     = option_control[tcp_pkg::OPT_PSA];
    wire [2:0] prescale_ratio_field = option_control[tcp_pkg::OPT_PS_LSB +: 3];
    wire       overflow_flag        = interrupt_control[tcp_pkg::INT_FLAG];
    wire       overflow_irq_enable  = interrupt_control[tcp_pkg::INT_IE];

    // ----------------------------------------------------------------
    // Phase clocks: four clock periods per instruction cycle
    // ----------------------------------------------------------------
    wire q2_en = phase == tcp_pkg::PH_Q2;
    wire q4_en = phase == tcp_pkg::PH_Q4;
    // High through the second half of each instruction cycle
    wire instr_level = phase[1];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    // ----------------------------------------------------------------
    // Pin synchroniser: a change counts once two stages agree
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            pin_s3    <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_s1 <= external_count_input;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3)
                pin_level <= pin_s3;
        end
    end

    // ----------------------------------------------------------------
    // Source selection and the shared prescaler
    // ----------------------------------------------------------------
    // Inverting the pin makes falling edges look like rising ones
    wire pin_edge_src = pin_level ^ source_edge_select;
    wire timer_src    = clock_source_select ? pin_edge_src : instr_level;
    // Prescaler feeds from whichever side owns it
    wire pre_src      = prescaler_assign ? watchdog_tick : timer_src;
    // Writes clear it only while the timer owns it
    wire pre_clear    = prescaler_assign ? watchdog_clear_op : wr_count;
    wire pre_out;
    wire [7:0] pre_count;

    // Counter value stays internal; no register decode reaches it
    tcp_prescaler u_prescaler (
        .clock     (clock),
        .rst_b     (rst_b),
        .src       (pre_src),
        .clear     (pre_clear),
        .ratio     (prescale_ratio_field),
        .pre_out   (pre_out),
        .pre_count (pre_count)
    );

    // Side without the prescaler runs undivided
    wire timer_in = prescaler_assign ? timer_src : pre_out;
    wire wdt_in   = prescaler_assign ? pre_out : watchdog_tick;

    // ----------------------------------------------------------------
    // Sampling on Q2 and Q4; a rise between samples is one increment
    // ----------------------------------------------------------------
    // Limitation: levels shorter than two phases may be missed
    // Reset option selects inverted pin, idle high: start high, no false step
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sample    <= 1'b1;
            inc_pulse <= 1'b0;
        end else if (q2_en | q4_en) begin
            sample    <= timer_in;
            inc_pulse <= timer_in & ~sample;
        end else begin
            inc_pulse <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Write inhibit: two instruction cycles after a count write
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            inhibit <= 2'h0;
        else if (wr_count)
            inhibit <= tcp_pkg::INHIBIT_CYCLES;
        else if (q4_en && inhibit != 2'h0)
            inhibit <= inhibit - 2'h1;
    end

    // ----------------------------------------------------------------
    // Count register
    // ----------------------------------------------------------------
    wire do_inc   = inc_pulse & ~sleep_mode & (inhibit == 2'h0);
    wire wrap     = do_inc & (count_register == 8'hFF) & ~wr_count;
    wire [7:0] next_count = wr_count ? wdata
                          : do_inc   ? count_register + 8'h01
                          : count_register;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            count_register <= tcp_pkg::RST_COUNT;
        else
            count_register <= next_count;
    end

    // ----------------------------------------------------------------
    // Interrupt control: the wrap wins over a clearing write
    // ----------------------------------------------------------------
    wire [7:0] next_intctl = (wr_intctl ? wdata : interrupt_control)
                           | ({7'h00, wrap} << tcp_pkg::INT_FLAG);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            interrupt_control <= tcp_pkg::RST_INTCTL;
        else
            interrupt_control <= next_intctl;
    end

    // ----------------------------------------------------------------
    // Option and port direction registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            option_control   <= tcp_pkg::RST_OPTION;
            port_a_direction <= tcp_pkg::RST_PORTA_DIR;
        end else if (wr_en) begin
            if (hit_option)
                option_control <= wdata;
            if (hit_porta)
                port_a_direction <= wdata & tcp_pkg::PORTA_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Read path: data stands one cycle after the strobe, else zero
    // ----------------------------------------------------------------
    wire [7:0] rd_mux = hit_count  ? count_register
                      : hit_intctl ? interrupt_control
                      : hit_option ? option_control
                      : hit_porta  ? port_a_direction
                      : 8'h00;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            rdata <= 8'h00;
        else
            rdata <= rd_en ? rd_mux : 8'h00;
    end

    // ----------------------------------------------------------------
    // Outputs: masked overflow request and watchdog timeout pulse
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            overflow_irq     <= 1'b0;
            wdt_prev         <= 1'b0;
            watchdog_timeout <= 1'b0;
        end else begin
            overflow_irq     <= overflow_flag & overflow_irq_enable;
            wdt_prev         <= wdt_in;
            watchdog_timeout <= wdt_in & ~wdt_prev;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_load;
        wr_count |=> count_register == $past(wdata) && inhibit == tcp_pkg::INHIBIT_CYCLES;
    endproperty
    a_load: assert property (p_load) else $error("count load or inhibit wrong");

    property p_hold;
        inhibit != 2'h0 && !wr_count |=> $stable(count_register);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while inhibited");

    property p_step;
        inc_pulse && !sleep_mode && inhibit == 2'h0 && !wr_count
            |=> count_register == $past(count_register) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count missed increment");

    property p_sample_time;
        inc_pulse |-> $past(q2_en) || $past(q4_en);
    endproperty
    a_sample_time: assert property (p_sample_time) else $error("off-phase inc");

    property p_wrap;
        wrap |=> overflow_flag ##1 overflow_irq == $past(overflow_irq_enable);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not set flag");

    property p_mask;
        !overflow_irq_enable ##1 !overflow_irq_enable |-> !overflow_irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked request seen");

    property p_sticky;
        overflow_flag && !wr_intctl |=> overflow_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped by itself");

    property p_sleep;
        sleep_mode && !wr_count |=> $stable(count_register);
    endproperty
    a_sleep: assert property (p_sleep) else $error("count moved in sleep");

    property p_wdt_clear;
        prescaler_assign && watchdog_clear_op |=> pre_count == 8'h00;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("prescaler kept");

    property p_ext_mode;
        clock_source_select ##1 clock_source_select ##1 clock_source_select
            && $rose(pin_level) && !source_edge_select && prescaler_assign
            |-> ##[1:8] $rose(sample);
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("edge not sampled");

    c_overflow: cover property (wrap);
    c_ext_inc:  cover property (clock_source_select && do_inc);
    c_inhibit:  cover property (inhibit != 2'h0 && inc_pulse);
    c_wdt:      cover property (watchdog_timeout && prescaler_assign);
endmodule

// >>> verification/tcp_ext_source.sv
// Model of the clock source that drives the external count input pin
`timescale 1ns/1ps
module tcp_ext_source (
    input  wire logic       clock,
    input  wire logic       idle_hi,
    input  wire logic       start,
    input  wire logic [7:0] pulses,
    input  wire logic [3:0] half,
    output logic            pin,
    output logic            busy
);
    // ----------------------------------------------------------------
    // Pulse train
    // ----------------------------------------------------------------
    // Idle level follows idle_hi; a burst inverts it for half clocks
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clock);
            if (start) begin
                busy <= 1'b1;
                for (int i = 0; i < 2 * pulses; i++) begin
                    pin <= ~pin;
                    repeat (half) @(posedge clock);
                end
                busy <= 1'b0;
            end else begin
                pin <= idle_hi;
            end
        end
    end
endmodule

// >>> verification/tcp_timer_bench.sv
// Self-checking bench of the timer/counter with prescaler
`timescale 1ns/1ps
module tcp_timer_bench;
    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic       sleep_mode = 1'b0;
    logic       wd_clear = 1'b0;
    logic       wd_tick = 1'b0;
    logic       idle_hi = 1'b0;
    logic       start = 1'b0;
    logic [7:0] pulses = 8'h00;
    logic [7:0] rdata;
    logic [7:0] porta_dir;
    logic       ext_pin;
    logic       overflow_irq;
    logic       wd_timeout;
    logic       busy;
    logic [7:0] v0;
    logic [7:0] v1;
    int         bad_count = 0;
    int         tests_run = 0;
    int         cycles = 0;
    int         timeouts = 0;

    tcp_timer u_dut (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .external_count_input(ext_pin),
        .sleep_mode(sleep_mode), .watchdog_clear_op(wd_clear), .watchdog_tick(wd_tick),
        .overflow_irq(overflow_irq), .watchdog_timeout(wd_timeout),
        .port_a_direction(porta_dir)
    );
    tcp_ext_source u_src (
        .clock(clock), .idle_hi(idle_hi), .start(start), .pulses(pulses),
        .half(4'h4), .pin(ext_pin), .busy(busy)
    );

    // ----------------------------------------------------------------
    // Clock, hang guard and watchdog pulse tally
    // ----------------------------------------------------------------
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (wd_timeout === 1'b1) begin
            timeouts <= timeouts + 1;
        end
        if (cycles == 30000) begin
            bad_count++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Bus and compare helpers
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Count gain between two reads exactly n clocks apart
    task automatic gain(input int n, output logic [7:0] d);
        rd(tcp_pkg::ADDR_COUNT, v0);
        cyc(n - 2);
        rd(tcp_pkg::ADDR_COUNT, v1);
        d = v1 - v0;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            wd_tick <= 1'b1;
            cyc(3);
            wd_tick <= 1'b0;
            cyc(3);
        end
    endtask
    task automatic wclr();
        @(posedge clock);
        wd_clear <= 1'b1;
        @(posedge clock);
        wd_clear <= 1'b0;
    endtask
    // Timer to watchdog move: clear both, park at a long ratio, clear again
    task automatic to_wdog(input logic [7:0] opt);
        wclr();
        wr(tcp_pkg::ADDR_COUNT, 8'h00);
        wr(tcp_pkg::ADDR_OPTION, opt | 8'h07);
        wclr();
        wr(tcp_pkg::ADDR_OPTION, opt);
    endtask
    // Move the pin level, then check the count step after the sync delay
    task automatic step(input logic lvl, input logic [7:0] inc);
        @(posedge clock);
        idle_hi <= lvl;
        cyc(12);
        rd(tcp_pkg::ADDR_COUNT, v1);
        v0 = v0 + inc;
        chk("count after pin edge", v0, v1);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(tcp_pkg::ADDR_OPTION, v0);
        chk("option", 8'hFF, v0);
        rd(tcp_pkg::ADDR_INTCTL, v0);
        chk("intctl", 8'h00, v0);
        chk("dir", 8'h1F, porta_dir);
        wr(tcp_pkg::ADDR_PORTA_DIR, 8'hFF);
        rd(tcp_pkg::ADDR_PORTA_DIR, v0);
        chk("dir rd", 8'h1F, v0);
        rd(8'h02, v0);
        chk("unmapped", 8'h00, v0);
    endtask
    task automatic t_timer();
        wr(tcp_pkg::ADDR_OPTION, 8'h08);
        wr(tcp_pkg::ADDR_COUNT, 8'h10);
        cyc(40);
        rd(tcp_pkg::ADDR_COUNT, v0);
        chk("inhibit", 8'h01, 8'((v0 >= 8'h17) && (v0 <= 8'h19)));
        gain(32, v1);
        chk("instr rate", 8'h08, v1);
    endtask
    task automatic t_overflow();
        wr(tcp_pkg::ADDR_INTCTL, 8'h20);
        wr(tcp_pkg::ADDR_COUNT, 8'hFE);
        for (int i = 0; i < 60 && overflow_irq !== 1'b1; i++) @(posedge clock);
        chk("irq at wrap", 8'h01, 8'(overflow_irq));
        rd(tcp_pkg::ADDR_INTCTL, v0);
        chk("flag", 8'h24, v0);
        rd(tcp_pkg::ADDR_INTCTL_HI, v0);
        chk("flag mirror", 8'h24, v0);
        cyc(20);
        chk("irq held", 8'h01, 8'(overflow_irq));
        wr(tcp_pkg::ADDR_INTCTL, 8'h04);
        cyc(2);
        chk("irq masked", 8'h00, 8'(overflow_irq));
        wr(tcp_pkg::ADDR_INTCTL, 8'h24);
        cyc(2);
        chk("irq unmasked", 8'h01, 8'(overflow_irq));
        wr(tcp_pkg::ADDR_INTCTL, 8'h20);
        cyc(2);
        chk("irq cleared", 8'h00, 8'(overflow_irq));
    endtask
    task automatic t_sleep();
        @(posedge clock);
        sleep_mode <= 1'b1;
        gain(40, v1);
        chk("sleep gain", 8'h00, v1);
        @(posedge clock);
        sleep_mode <= 1'b0;
    endtask
    // Four periods of 4 * 2^(n+1) clocks give four steps for every ratio
    task automatic t_ratio();
        wclr();
        for (int n = 0; n < 8; n++) begin
            wr(tcp_pkg::ADDR_OPTION, 8'(n));
            wr(tcp_pkg::ADDR_COUNT, 8'h00);
            cyc(16);
            gain(32 << n, v1);
            chk("ratio gain", 8'h04, v1);
        end
    endtask
    // Second write lands before the 128-step rise; no step may follow
    task automatic t_clear();
        wr(tcp_pkg::ADDR_OPTION, 8'h07);
        wr(tcp_pkg::ADDR_COUNT, 8'h00);
        cyc(400);
        wr(tcp_pkg::ADDR_COUNT, 8'h00);
        cyc(400);
        rd(tcp_pkg::ADDR_COUNT, v0);
        chk("cleared prescaler", 8'h00, v0);
    endtask
    task automatic t_edges();
        to_wdog(8'h28);
        cyc(12);
        rd(tcp_pkg::ADDR_COUNT, v0);
        step(1'b1, 8'h01);
        step(1'b0, 8'h00);
        wr(tcp_pkg::ADDR_OPTION, 8'h38);
        cyc(12);
        rd(tcp_pkg::ADDR_COUNT, v0);
        step(1'b1, 8'h00);
        step(1'b0, 8'h01);
    endtask
    task automatic t_ext_div();
        wclr();
        for (int n = 0; n < 2; n++) begin
            wr(tcp_pkg::ADDR_OPTION, 8'h20 | 8'(n));
            wr(tcp_pkg::ADDR_COUNT, 8'h00);
            cyc(12);
            @(posedge clock);
            pulses <= 8'h08;
            start <= 1'b1;
            @(posedge clock);
            start <= 1'b0;
            cyc(2);
            for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clock);
            cyc(12);
            rd(tcp_pkg::ADDR_COUNT, v0);
            chk("ext divided", 8'h04 >> n, v0);
        end
    endtask
    task automatic t_wdog();
        int t0;
        wr(tcp_pkg::ADDR_OPTION, 8'h00);
        cyc(4);
        t0 = timeouts;
        tick(4);
        cyc(4);
        chk("wdog undivided", 8'h04, 8'(timeouts - t0));
        to_wdog(8'h09);
        wclr();
        cyc(4);
        t0 = timeouts;
        tick(1);
        wclr();
        tick(1);
        cyc(4);
        chk("wdog cleared", 8'h00, 8'(timeouts - t0));
        tick(1);
        cyc(4);
        chk("wdog divided", 8'h01, 8'(timeouts - t0));
    endtask

    // ----------------------------------------------------------------
    // Verdict
    // ----------------------------------------------------------------
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence, reset held for five clocks first
    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_timer();
        t_overflow();
        t_sleep();
        t_ratio();
        t_clear();
        t_edges();
        t_ext_div();
        t_wdog();
        results();
    end
endmodule
